/* rtl/sac_defines.svh */
// constants for the converter result readout block
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_CLK_PERIOD_NS 10
`define SAC_CONV_TIME_NS  1000
`define SAC_CONV_CYCLES   (`SAC_CONV_TIME_NS / `SAC_CLK_PERIOD_NS)
`define SAC_RES_BITS      16
`define SAC_FALLS_PLAIN   5'h10
`define SAC_FALLS_BUSY    5'h11
`define SAC_FIFO_DEPTH    32
`define SAC_SYNC_CVS      0
`define SAC_SYNC_DIN      1
`define SAC_SYNC_SCK      2
`endif

/* rtl/sac_pkg.sv */
// types shared by the converter result readout block
package sac_pkg;
  typedef enum logic [1:0] {
    ST_ACQ   = 2'b00,
    ST_CONV  = 2'b01,
    ST_WAIT  = 2'b10,
    ST_SHIFT = 2'b11
  } sac_state_type;
endpackage

/* rtl/sac_readout.sv */
// result fifo and chip-select serial readout of a 16-bit sar converter
// Function
// - result is unsigned straight binary code
// - span equals reference, step is ref/2^16
// - convert-start rise samples select: cs or daisy
// - optional busy bit precedes result bits
// - convert-start rise: output hi-z, sample, convert
// - conversion finishes regardless of pin activity
// - after conversion: acquisition, power down, hold result
// - 3-wire plain: convert-start high at completion
// - 3-wire plain: convert-start fall presents msb
// - lower bits follow on shift-clock falls, msb first
// - 3-wire plain: hi-z at 16th fall or rise
// - each bit valid across both shift-clock edges
// - 3-wire busy: convert-start low at completion
// - busy modes: drive low busy bit at completion
// - 3-wire busy: hi-z at 17th fall or rise
// - 4-wire plain: select high at completion
// - 4-wire plain: select fall presents msb
// - 4-wire plain: hi-z at 16th fall or select rise
// - 4-wire busy: select low, hi-z at 17th
// - shift clock never times the conversion
`timescale 1ns/100ps
`include "sac_defines.svh"

module sac_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  // depth must be a power of two; the extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire do_wr = i_in_valid && !full;
  wire do_rd = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_clock)
  begin
    if (do_wr)
      mem_q[wr_q[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (do_wr)
        wr_q <= wr_q + 1'b1;
      if (do_rd)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

module sac_readout
  import sac_pkg::*;
#(
  parameter int CONV_CYCLES = `SAC_CONV_CYCLES,
  parameter int FIFO_DEPTH  = `SAC_FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_reset_n,
  // host-side pins
  input  wire logic                     i_convert_start_pin,
  input  wire logic                     i_serial_in,
  input  wire logic                     i_shift_clock,
  output logic                          o_serial_out,
  output logic                          o_serial_out_oe,
  // converter core
  input  wire logic [`SAC_RES_BITS-1:0] i_sample_code,
  output logic                          o_sample_ready,
  output logic                          o_converting,
  output logic                          o_powered_down,
  output logic                          o_mode_cs
);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  // pin synchronisers: stage one feeds stage two only
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  wire  [2:0] pins = {i_shift_clock, i_serial_in, i_convert_start_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      // shift clock idles low; resetting its stages high would fake a fall
      localparam logic IDLE = (g == `SAC_SYNC_SCK) ? 1'b0 : 1'b1;
      always_ff @(posedge i_clock or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          sync1_q[g] <= IDLE;
          sync2_q[g] <= IDLE;
          prev_q[g]  <= IDLE;
        end
        else
        begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
          prev_q[g]  <= sync2_q[g];
        end
      end
    end
  endgenerate

  // decoded pin events
  wire cvs_s     = sync2_q[`SAC_SYNC_CVS];
  wire din_s     = sync2_q[`SAC_SYNC_DIN];
  wire cs_rise   = cvs_s && !prev_q[`SAC_SYNC_CVS];
  wire sclk_fall = !sync2_q[`SAC_SYNC_SCK] && prev_q[`SAC_SYNC_SCK];
  // the active-low select is either line: convert-start in 3-wire, din in 4-wire
  wire sel_s     = cvs_s && din_s;
  wire sel_prev  = prev_q[`SAC_SYNC_CVS] && prev_q[`SAC_SYNC_DIN];
  wire sel_fall  = sel_prev && !sel_s;
  wire sel_rise  = !sel_prev && sel_s;

  // fifo between the sampled code and the output shifter
  logic                     fifo_push;
  logic                     fifo_pop;
  logic                     fifo_valid;
  logic [`SAC_RES_BITS-1:0] fifo_code;

  sac_fifo #(
    .WIDTH (`SAC_RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (fifo_push),
    .i_in_data   (i_sample_code),
    .o_in_ready  (o_sample_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_code),
    .i_out_ready (fifo_pop)
  );

  sac_state_type state_q;
  sac_state_type state_d;
  logic [15:0]   cnt_q;
  logic [15:0]   cnt_d;
  logic [4:0]    falls_q;
  logic [4:0]    falls_d;
  logic [16:0]   shreg_q;
  logic [16:0]   shreg_d;
  logic          oe_q;
  logic          oe_d;
  logic          mode_cs_q;
  logic          mode_cs_d;

  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    falls_d   = falls_q;
    shreg_d   = shreg_q;
    oe_d      = oe_q;
    mode_cs_d = mode_cs_q;
    fifo_push = 1'b0;
    fifo_pop  = 1'b0;
    if (cs_rise && state_q != ST_CONV)
    begin
      state_d   = ST_CONV;
      cnt_d     = CONV_LAST;
      oe_d      = 1'b0;
      mode_cs_d = din_s;
      fifo_push = 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_ACQ:
        begin
          state_d = ST_ACQ;
        end
        ST_CONV:
        begin
          // internal count only; shift clock is not looked at, pins only for the select level at completion
          if (cnt_q != 16'h0000)
            cnt_d = cnt_q - 16'h0001;
          else if (fifo_valid)
          begin
            fifo_pop = 1'b1;
            if (!mode_cs_q)
              state_d = ST_ACQ;
            else if (!sel_s)
            begin
              // select low at completion asks for the busy bit
              shreg_d = {1'b0, fifo_code};
              falls_d = `SAC_FALLS_BUSY;
              oe_d    = 1'b1;
              state_d = ST_SHIFT;
            end
            else
            begin
              shreg_d = {fifo_code, 1'b0};
              falls_d = `SAC_FALLS_PLAIN;
              state_d = ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          if (sel_fall)
          begin
            oe_d    = 1'b1;
            state_d = ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (sel_rise)
          begin
            oe_d    = 1'b0;
            state_d = ST_ACQ;
          end
          else if (sclk_fall)
          begin
            // bit changes only on a fall, so it stands across the rise
            shreg_d = {shreg_q[15:0], 1'b0};
            falls_d = falls_q - 5'h01;
            if (falls_q == 5'h01)
            begin
              oe_d    = 1'b0;
              state_d = ST_ACQ;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q   <= ST_ACQ;
      cnt_q     <= 16'h0000;
      falls_q   <= 5'h00;
      shreg_q   <= 17'h00000;
      oe_q      <= 1'b0;
      mode_cs_q <= 1'b1;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      falls_q   <= falls_d;
      shreg_q   <= shreg_d;
      oe_q      <= oe_d;
      mode_cs_q <= mode_cs_d;
    end
  end

  assign o_serial_out    = shreg_q[16];
  assign o_serial_out_oe = oe_q;
  assign o_converting    = (state_q == ST_CONV);
  assign o_powered_down  = (state_q != ST_CONV);
  assign o_mode_cs       = mode_cs_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_load_busy;
    state_q == ST_CONV && state_d == ST_SHIFT;
  endsequence

  sequence s_load_plain;
    state_q == ST_CONV && state_d == ST_WAIT;
  endsequence

  chk_start_hiz: assert property (cs_rise |=> !o_serial_out_oe && o_converting)
    else $error("output not hi-z after convert start");

  chk_mode_sample: assert property (
    (cs_rise && state_q != ST_CONV) |=> o_mode_cs == $past(din_s))
    else $error("mode not taken from select at convert start");

  chk_conv_count: assert property (
    (state_q == ST_CONV && cnt_q != 16'h0000) |=> state_q == ST_CONV
      && cnt_q == $past(cnt_q) - 16'h0001)
    else $error("conversion count disturbed");

  chk_conv_end: assert property (
    (state_q == ST_CONV && state_d != ST_CONV) |-> cnt_q == 16'h0000)
    else $error("conversion ended before its count");

  chk_busy_low: assert property (
    s_load_busy |=> o_serial_out_oe && !o_serial_out && falls_q == `SAC_FALLS_BUSY)
    else $error("busy bit not driven low with 17 falls");

  chk_plain_wait: assert property (
    s_load_plain |=> !o_serial_out_oe && falls_q == `SAC_FALLS_PLAIN)
    else $error("plain mode drove output at completion");

  chk_msb_first: assert property (
    (state_q == ST_WAIT && sel_fall && !cs_rise) |=> o_serial_out_oe
      && o_serial_out == $past(shreg_q[16]) && falls_q == `SAC_FALLS_PLAIN)
    else $error("msb not presented on select fall");

  chk_shift_step: assert property (
    (state_q == ST_SHIFT && sclk_fall && !sel_rise && !cs_rise && falls_q > 5'h01)
      |=> o_serial_out_oe && o_serial_out == $past(shreg_q[15]))
    else $error("next bit not shifted on clock fall");

  chk_last_hiz: assert property (
    (state_q == ST_SHIFT && sclk_fall && falls_q == 5'h01) |=> !o_serial_out_oe)
    else $error("output not released at last fall");

  chk_sel_release: assert property (
    (o_serial_out_oe && sel_rise) |=> !o_serial_out_oe ##1 !o_serial_out_oe)
    else $error("output not released on select rise");

  chk_idle_sclk: assert property (
    ((state_q == ST_ACQ || state_q == ST_WAIT) && !cs_rise && !sel_fall)
      |=> $stable(shreg_q) && $stable(falls_q))
    else $error("shift advanced while output hi-z");
endmodule

/* tb/sac_host.sv */
// host controller model that drives the readout pins and collects bits
`timescale 1ns/100ps
module sac_host
(
  // clock
  input  wire logic i_clock,
  // device pins
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe,
  output logic      o_convert_start_pin,
  output logic      o_serial_in,
  output logic      o_shift_clock
);
  initial
  begin
    o_convert_start_pin = 1'b1;
    o_serial_in         = 1'b1;
    o_shift_clock       = 1'b0;
  end

  // levels hold five cycles, longer than the three-flop sync needs
  task automatic pins(input logic cs, input logic din);
    @(posedge i_clock);
    o_convert_start_pin <= cs;
    o_serial_in         <= din;
    repeat (4) @(posedge i_clock);
  endtask

  // shift clock of 160 ns, idle low outside frames; a released line reads its pull-up
  task automatic shift(input int n, output logic [16:0] word);
    word = '0;
    repeat (n)
    begin
      @(posedge i_clock);
      o_shift_clock <= 1'b1;
      repeat (8) @(posedge i_clock);
      word = {word[15:0], i_serial_out_oe ? i_serial_out : 1'b1};
      o_shift_clock <= 1'b0;
      repeat (7) @(posedge i_clock);
    end
  endtask
endmodule

/* tb/tb_sar_adc_chip_select_serial_readout.sv */
// self-checking bench for the converter result readout
`timescale 1ns/100ps
module tb_sar_adc_chip_select_serial_readout;
  logic        i_clock       = 1'b0;
  logic        i_reset_n     = 1'b0;
  logic [15:0] i_sample_code = 16'h0000;
  logic        cs, din, sclk, dout, dout_oe, conv, pdown, mode_cs, ready;
  logic [16:0] word;
  int          error_cnt     = 0;
  int          compares      = 0;

  sac_readout #(.CONV_CYCLES(20), .FIFO_DEPTH(32)) dut_u
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_convert_start_pin(cs),
    .i_serial_in(din), .i_shift_clock(sclk), .o_serial_out(dout),
    .o_serial_out_oe(dout_oe), .i_sample_code(i_sample_code),
    .o_sample_ready(ready), .o_converting(conv), .o_powered_down(pdown),
    .o_mode_cs(mode_cs)
  );
  sac_host host_u
  (
    .i_clock(i_clock), .i_serial_out(dout), .i_serial_out_oe(dout_oe),
    .o_convert_start_pin(cs), .o_serial_in(din), .o_shift_clock(sclk)
  );

  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // code is moved away after the rise so a late capture shows up
  task automatic start(input logic d, input logic [15:0] code);
    i_sample_code <= code;
    host_u.pins(1'b0, d);
    host_u.pins(1'b1, d);
    cmp(17'({conv, dout_oe, mode_cs}), 17'({2'b10, d}));
    i_sample_code <= ~code;
  endtask

  task automatic finish_conv;
    int n;
    n = 0;
    while (conv === 1'b1 && n < 100)
    begin
      @(posedge i_clock);
      n++;
    end
    repeat (3) @(posedge i_clock);
    cmp(17'({conv, pdown}), 17'h1);
  endtask

  task automatic run(input logic four, input logic busy, input logic [15:0] code);
    start(1'b1, code);
    if (busy)
      host_u.pins(four, ~four);
    finish_conv();
    cmp(17'({dout_oe, dout & busy}), 17'({busy, 1'b0}));
    if (!busy)
    begin
      host_u.shift(2, word);
      host_u.pins(four, ~four);
    end
    host_u.shift(16 + busy, word);
    cmp(word, {1'b0, code});
    repeat (6) @(posedge i_clock);
    cmp(17'(dout_oe), 17'h0);
    host_u.pins(1'b1, 1'b1);
    finish_conv();
  endtask

  task automatic abort_read(input logic [15:0] code);
    start(1'b1, code);
    finish_conv();
    host_u.pins(1'b0, 1'b1);
    host_u.shift(8, word);
    cmp(word, 17'(code[15:8]));
    host_u.pins(1'b1, 1'b1);
    cmp(17'({conv, dout_oe}), 17'h2);
    host_u.pins(1'b0, 1'b1);
    host_u.pins(1'b1, 1'b1);
    finish_conv();
    host_u.pins(1'b0, 1'b1);
    host_u.shift(16, word);
    cmp(word, {1'b0, ~code});
    host_u.pins(1'b1, 1'b1);
    finish_conv();
  endtask

  task automatic daisy;
    start(1'b0, 16'h1234);
    finish_conv();
    host_u.shift(4, word);
    cmp(17'(dout_oe), 17'h0);
    host_u.pins(1'b1, 1'b1);
  endtask

  initial
  begin
    forever #5 i_clock = ~i_clock;
  end

  // whole run is a few thousand cycles
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    cmp(17'({dout_oe, conv, pdown, mode_cs, ready}), 17'h07);
    repeat (2) @(posedge i_clock);
    run(1'b0, 1'b0, 16'hA5C3);
    run(1'b0, 1'b1, 16'hFFFF);
    run(1'b1, 1'b0, 16'h8001);
    run(1'b1, 1'b1, 16'h7FFE);
    abort_read(16'h3C5A);
    daisy();
    run(1'b0, 1'b0, 16'h0000);
    close_out();
  end
endmodule
